// ===== rtl/sgc_calib.v
// Shading gain calibration, correction file handling and pixel correction
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defines.vh"

// Summary of operation
// - Gain calibration on raw, uncorrected pixels
// - Optional dark offset subtraction before gain computation
// - Writing generate field starts calibration
// - Collect 128 triggered lines before computing
// - Line and data valid keep toggling
// - No command acknowledged while collecting
// - Average each pixel over 128 lines
// - Gain raises each pixel to brightest average
// - Store gain set into user file
// - New gain set activates user file
// - User or factory file selectable as active
// - Activation copies file into working memory
// - Correction uses working memory gains only, after dark offset subtraction
// - Reload working memory from active file at reset
// - Bulk command copies factory into user file
// - Bulk data reads user or factory file
// - Separate sets for single-line and other modes
// - Factory file never written by host
module sgc_calib (
    input wire clk,
    input wire rstn,
    input wire por_n,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_r,
    output reg cmd_ack_r,
    input wire external_line_trigger,
    input wire pix_valid,
    input wire [11:0] pix_data,
    output reg line_valid_r,
    output reg data_valid_r,
    output reg [11:0] pix_out_r,
    output reg busy_r
);

localparam ST_IDLE = 6'h01;
localparam ST_LOAD = 6'h02;
localparam ST_COLLECT = 6'h04;
localparam ST_MAX = 6'h08;
localparam ST_DIV = 6'h10;
localparam ST_COPY = 6'h20;

reg [5:0] state_r;
reg [4:0] idx_r;
reg [3:0] pix_idx_r;
reg [7:0] trig_cnt_r;
reg line_armed_r;
reg [11:0] max_r;
reg use_dark_r;
reg [1:0] gen_code_r;
reg active_user_r;
reg single_mode_r;
reg corr_en_r;
reg bulk_factory_r;
reg [4:0] bulk_idx_r;
reg div_start_r;
reg trg_s1_r, trg_s2_r, trg_s3_r, trg_lvl_r;

reg [18:0] acc_mem [0:`SGC_PIX_N-1];
reg [15:0] user_mem [0:`SGC_ENT_N-1];
reg [15:0] work_mem [0:`SGC_ENT_N-1];
reg [11:0] dark_mem [0:`SGC_PIX_N-1];

wire div_done;
wire [23:0] div_quot;
wire [15:0] gain_sat;
wire trig_rise;
wire line_end;
wire collecting;
wire wr_ok;
wire idle_wr;
wire start_cal;
wire bulk_cmd;
wire last_gain;
wire act_user_now;
wire act_sel_now;
wire [11:0] cal_sample;
wire [15:0] bulk_word;
wire [11:0] avg_now;
reg user_we;
reg [4:0] user_wa;
reg [15:0] user_wd;
integer i;

// Factory file is a fixed unity-gain image
function [15:0] factory_val;
    input [4:0] idx;
    begin
        factory_val = `SGC_GAIN_ONE;
    end
endfunction

// Subtract dark offset, clamped at zero
function [11:0] sub_clamp;
    input [11:0] a;
    input [11:0] b;
    begin
        sub_clamp = (a > b) ? (a - b) : 12'h000;
    end
endfunction

// Apply 4.12 gain with saturation
function [11:0] mul_sat;
    input [11:0] a;
    input [15:0] g;
    reg [27:0] p;
    begin
        p = a * g;
        mul_sat = (|p[27:24]) ? `SGC_DATA_MAX : p[23:12];
    end
endfunction

// Trigger pin synchroniser; a level counts once stages two and three agree
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        trg_s1_r <= 1'b0;
        trg_s2_r <= 1'b0;
        trg_s3_r <= 1'b0;
        trg_lvl_r <= 1'b0;
    end else begin
        trg_s1_r <= external_line_trigger;
        trg_s2_r <= trg_s1_r;
        trg_s3_r <= trg_s2_r;
        if (trg_s2_r == trg_s3_r) begin
            trg_lvl_r <= trg_s3_r;
        end
    end
end

assign trig_rise = trg_s2_r & trg_s3_r & ~trg_lvl_r;
assign line_end = pix_valid && (pix_idx_r == `SGC_PIX_LAST);
assign collecting = (state_r == ST_COLLECT);
assign wr_ok = reg_wr && !collecting;
assign idle_wr = reg_wr && (state_r == ST_IDLE);
assign start_cal = idle_wr && (reg_addr == `SGC_REG_CTRL) &&
                   (reg_wdata[1] == 1'b1);
assign bulk_cmd = idle_wr && (reg_addr == `SGC_REG_BULK_CTRL);
assign last_gain = (state_r == ST_DIV) && div_done && (idx_r[3:0] == `SGC_PIX_LAST);
assign act_user_now = last_gain;
assign act_sel_now = bulk_cmd && (reg_wdata[1:0] == `SGC_BULK_ACTIVATE);
assign gain_sat = (|div_quot[23:16]) ? `SGC_GAIN_MAX : div_quot[15:0];
assign cal_sample = use_dark_r ? sub_clamp(pix_data, dark_mem[pix_idx_r])
                               : pix_data;
assign avg_now = acc_mem[idx_r[3:0]][18:`SGC_AVG_SHIFT];
assign bulk_word = bulk_factory_r ? factory_val(bulk_idx_r) : user_mem[bulk_idx_r];

// Active file link survives rstn; only power-on clears it
always @(posedge clk or negedge por_n) begin
    if (!por_n) begin
        active_user_r <= 1'b0;
    end else if (act_user_now) begin
        active_user_r <= 1'b1;
    end else if (act_sel_now) begin
        active_user_r <= ~reg_wdata[`SGC_BULK_SEL_BIT];
    end
end

// Main sequencer: load, collect, find maximum, divide, copy
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state_r <= ST_LOAD;
        idx_r <= 5'h00;
        trig_cnt_r <= 8'h00;
        line_armed_r <= 1'b0;
        max_r <= 12'h000;
        use_dark_r <= 1'b0;
        gen_code_r <= `SGC_GEN_NONE;
        div_start_r <= 1'b0;
    end else begin
        div_start_r <= 1'b0;
        case (state_r)
            ST_IDLE: begin
                idx_r <= 5'h00;
                if (start_cal) begin
                    gen_code_r <= reg_wdata[1:0];
                    use_dark_r <= (reg_wdata[1:0] == `SGC_GEN_GAIN_DARK);
                    trig_cnt_r <= 8'h00;
                    line_armed_r <= 1'b0;
                    state_r <= ST_COLLECT;
                end else if (act_sel_now) begin
                    state_r <= ST_LOAD;
                end else if (bulk_cmd && (reg_wdata[1:0] == `SGC_BULK_COPY)) begin
                    state_r <= ST_COPY;
                end
            end
            ST_COLLECT: begin
                if (trig_rise && (trig_cnt_r != `SGC_LINES)) begin
                    trig_cnt_r <= trig_cnt_r + 8'h01;
                    line_armed_r <= 1'b1;
                end else if (line_end) begin
                    line_armed_r <= 1'b0;
                end
                if ((trig_cnt_r == `SGC_LINES) && !line_armed_r) begin
                    max_r <= 12'h000;
                    idx_r <= 5'h00;
                    state_r <= ST_MAX;
                end
            end
            ST_MAX: begin
                if (avg_now > max_r) begin
                    max_r <= avg_now;
                end
                idx_r <= idx_r + 5'h01;
                if (idx_r[3:0] == `SGC_PIX_LAST) begin
                    idx_r <= 5'h00;
                    div_start_r <= 1'b1;
                    state_r <= ST_DIV;
                end
            end
            ST_DIV: begin
                if (div_done) begin
                    idx_r <= idx_r + 5'h01;
                    if (last_gain) begin
                        idx_r <= 5'h00;
                        gen_code_r <= `SGC_GEN_NONE;
                        state_r <= ST_LOAD;
                    end else begin
                        div_start_r <= 1'b1;
                    end
                end
            end
            ST_LOAD, ST_COPY: begin
                idx_r <= idx_r + 5'h01;
                if (idx_r == `SGC_ENT_LAST) begin
                    idx_r <= 5'h00;
                    state_r <= ST_IDLE;
                end
            end
            default: begin
                state_r <= ST_IDLE;
            end
        endcase
    end
end

// User file write port: gain store, factory copy or host upload
always @* begin
    user_we = 1'b0;
    user_wa = bulk_idx_r;
    user_wd = reg_wdata[15:0];
    if ((state_r == ST_DIV) && div_done) begin
        user_we = 1'b1;
        user_wa = {single_mode_r, idx_r[3:0]};
        user_wd = gain_sat;
    end else if (state_r == ST_COPY) begin
        user_we = 1'b1;
        user_wa = idx_r;
        user_wd = factory_val(idx_r);
    end else if (idle_wr && (reg_addr == `SGC_REG_BULK_DATA) && !bulk_factory_r) begin
        user_we = 1'b1;
    end
end

// Storage arrays and accumulators
always @(posedge clk) begin
    if (user_we) begin
        user_mem[user_wa] <= user_wd;
    end
    if (state_r == ST_LOAD) begin
        work_mem[idx_r] <= active_user_r ? user_mem[idx_r] : factory_val(idx_r);
    end
    if (wr_ok && (reg_addr == `SGC_REG_DARK)) begin
        dark_mem[reg_wdata[19:16]] <= reg_wdata[11:0];
    end
    if (start_cal) begin
        for (i = 0; i < `SGC_PIX_N; i = i + 1) begin
            acc_mem[i] <= `SGC_ACC_ZERO;
        end
    end else if (collecting && line_armed_r && pix_valid) begin
        acc_mem[pix_idx_r] <= acc_mem[pix_idx_r] + {7'h00, cal_sample};
    end
end

// Register port, configuration and bulk pointer
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        reg_rdata_r <= 32'h00000000;
        cmd_ack_r <= 1'b0;
        single_mode_r <= 1'b0;
        corr_en_r <= 1'b0;
        bulk_factory_r <= 1'b0;
        bulk_idx_r <= 5'h00;
    end else begin
        cmd_ack_r <= (reg_wr || reg_rd) && !collecting;
        reg_rdata_r <= 32'h00000000;
        if (wr_ok && (reg_addr == `SGC_REG_MODE)) begin
            single_mode_r <= reg_wdata[0];
            corr_en_r <= reg_wdata[1];
        end
        if (bulk_cmd) begin
            bulk_factory_r <= reg_wdata[`SGC_BULK_SEL_BIT];
            bulk_idx_r <= reg_wdata[12:8];
        end else if (idle_wr && (reg_addr == `SGC_REG_BULK_DATA)) begin
            bulk_idx_r <= bulk_idx_r + 5'h01;
        end
        if (reg_rd && !collecting) begin
            case (reg_addr)
                `SGC_REG_CTRL: reg_rdata_r <= {30'h00000000, gen_code_r};
                `SGC_REG_STATUS: reg_rdata_r <= {24'h000000, trig_cnt_r[7:0] == `SGC_LINES,
                                                 state_r[5:0], active_user_r};
                `SGC_REG_MODE: reg_rdata_r <= {30'h00000000, corr_en_r, single_mode_r};
                `SGC_REG_BULK_CTRL: reg_rdata_r <= {19'h00000, bulk_idx_r, 3'h0,
                                                    bulk_factory_r, 4'h0};
                `SGC_REG_BULK_DATA: begin
                    reg_rdata_r <= {16'h0000, bulk_word};
                    bulk_idx_r <= bulk_idx_r + 5'h01;
                end
                default: reg_rdata_r <= 32'h00000000;
            endcase
        end
    end
end

// Pixel path: index, qualifiers and correction from working memory
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        pix_idx_r <= 4'h0;
        line_valid_r <= 1'b0;
        data_valid_r <= 1'b0;
        pix_out_r <= 12'h000;
        busy_r <= 1'b0;
    end else begin
        busy_r <= (state_r != ST_IDLE);
        if (trig_rise) begin
            pix_idx_r <= 4'h0;
        end else if (pix_valid) begin
            pix_idx_r <= pix_idx_r + 4'h1;
        end
        line_valid_r <= pix_valid;
        data_valid_r <= pix_valid;
        if (collecting) begin
            pix_out_r <= 12'h000;
        end else if (corr_en_r) begin
            pix_out_r <= mul_sat(sub_clamp(pix_data, dark_mem[pix_idx_r]),
                                 work_mem[{single_mode_r, pix_idx_r}]);
        end else begin
            pix_out_r <= pix_data;
        end
    end
end

// Gain = brightest average scaled by 4096 over this pixel's average
sgc_div u_div (
    .clk(clk),
    .rstn(rstn),
    .start(div_start_r),
    .dividend({max_r, 12'h000}),
    .divisor(avg_now),
    .done_r(div_done),
    .quot_r(div_quot)
);

endmodule // sgc_calib

`default_nettype wire

// ===== rtl/sgc_defines.vh
// Constants shared by the shading gain calibration block
`ifndef SGC_DEFINES_VH
`define SGC_DEFINES_VH

// Geometry of one line and of the correction files
`define SGC_PIX_N 16
`define SGC_PIX_LAST 4'hF
`define SGC_ENT_N 32
`define SGC_ENT_LAST 5'h1F
`define SGC_DATA_MAX 12'hFFF
`define SGC_ACC_ZERO 19'h00000

// Calibration line count and its averaging shift
`define SGC_LINES 8'h80
`define SGC_AVG_SHIFT 7

// Last step of the 24-bit quotient loop
`define SGC_DIV_LAST 5'h17

// Unity gain in 4.12 fixed point
`define SGC_GAIN_ONE 16'h1000
`define SGC_GAIN_MAX 16'hFFFF

// Register offsets (byte addresses)
`define SGC_REG_CTRL 8'h00
`define SGC_REG_STATUS 8'h04
`define SGC_REG_MODE 8'h08
`define SGC_REG_BULK_CTRL 8'h0C
`define SGC_REG_BULK_DATA 8'h10
`define SGC_REG_DARK 8'h14

// Generate field codes of the calibration control register
`define SGC_GEN_NONE 2'h0
`define SGC_GEN_GAIN 2'h2
`define SGC_GEN_GAIN_DARK 2'h3

// Bulk control command codes and field positions
`define SGC_BULK_NOP 2'h0
`define SGC_BULK_ACTIVATE 2'h1
`define SGC_BULK_COPY 2'h2
`define SGC_BULK_SEL_BIT 4
`define SGC_BULK_IDX_LSB 8
`define SGC_DARK_IDX_LSB 16

// Reset values
`define SGC_MODE_RST 2'h0

`endif

// ===== rtl/sgc_div.v
// Iterative restoring divider for gain computation
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defines.vh"

module sgc_div (
    input wire clk,
    input wire rstn,
    input wire start,
    input wire [23:0] dividend,
    input wire [11:0] divisor,
    output reg done_r,
    output reg [23:0] quot_r
);

reg run_r;
reg [4:0] cnt_r;
reg [11:0] rem_r;
reg [11:0] dsr_r;
reg [23:0] dvd_r;
wire [12:0] shifted;
wire ge;
wire [12:0] diff;

// One quotient bit per cycle
assign shifted = {rem_r, dvd_r[23]};
assign ge = (shifted >= {1'b0, dsr_r});
assign diff = shifted - {1'b0, dsr_r};

// Division sequencer; a zero divisor yields all ones
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        run_r <= 1'b0;
        cnt_r <= 5'h00;
        rem_r <= 12'h000;
        dsr_r <= 12'h000;
        dvd_r <= 24'h000000;
        done_r <= 1'b0;
        quot_r <= 24'h000000;
    end else begin
        done_r <= 1'b0;
        if (start) begin
            run_r <= 1'b1;
            cnt_r <= 5'h00;
            rem_r <= 12'h000;
            dsr_r <= divisor;
            dvd_r <= dividend;
        end else if (run_r) begin
            rem_r <= ge ? diff[11:0] : shifted[11:0];
            dvd_r <= {dvd_r[22:0], ge};
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `SGC_DIV_LAST) begin
                run_r <= 1'b0;
                done_r <= 1'b1;
                quot_r <= {dvd_r[22:0], ge};
            end
        end
    end
end

endmodule // sgc_div

`default_nettype wire

// ===== tb/sgc_calib_assertions.sv
// Checker for the shading gain calibration block
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defines.vh"
module sgc_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_r,
    input wire logic cmd_ack_r,
    input wire logic external_line_trigger,
    input wire logic pix_valid,
    input wire logic line_valid_r,
    input wire logic data_valid_r,
    input wire logic busy_r
);
    logic cal_r;
    logic trig_q_r;
    logic busy_q_r;
    logic [8:0] trig_cnt_r;
    wire start_w = reg_wr && reg_addr == `SGC_REG_CTRL && reg_wdata[1] && !busy_r;
    wire bulk_w = reg_wr && reg_addr == `SGC_REG_BULK_CTRL && !busy_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Count trigger rises from a calibration start until the sequencer idles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cal_r <= 1'b0;
            trig_q_r <= 1'b0;
            busy_q_r <= 1'b0;
            trig_cnt_r <= 9'h000;
        end else begin
            trig_q_r <= external_line_trigger;
            busy_q_r <= busy_r;
            if (start_w) begin
                cal_r <= 1'b1;
                trig_cnt_r <= 9'h000;
            end else if (busy_q_r && !busy_r) begin
                cal_r <= 1'b0;
            end else if (cal_r && external_line_trigger && !trig_q_r && !trig_cnt_r[8]) begin
                trig_cnt_r <= trig_cnt_r + 9'h001;
            end
        end
    end
    AST_LINE_VALID_FOLLOWS: assert property (1'b1 |=> line_valid_r == $past(pix_valid))
        else $error("line valid does not follow pixel valid");
    AST_DATA_VALID_PAIR: assert property (data_valid_r == line_valid_r)
        else $error("data valid differs from line valid");
    AST_ACK_NEEDS_STROBE: assert property (cmd_ack_r |-> $past(reg_wr || reg_rd))
        else $error("ack without a strobe");
    AST_ACK_WHEN_IDLE: assert property ((reg_wr || reg_rd) && !busy_r |=> cmd_ack_r)
        else $error("strobe in idle not acknowledged");
    AST_RDATA_ONLY_AFTER_READ: assert property (reg_rdata_r != 32'h0 |-> $past(reg_rd))
        else $error("read data without a read");
    AST_START_HOLDS_BUSY: assert property (start_w |=> ##1 busy_r [*7])
        else $error("calibration start did not hold busy");
    AST_LINES_BEFORE_END: assert property (
        cal_r && busy_q_r && !busy_r |-> trig_cnt_r >= 9'h080)
        else $error("calibration ended before enough lines");
    AST_ACTIVATE_LOADS: assert property (
        bulk_w && reg_wdata[1:0] == `SGC_BULK_ACTIVATE |-> ##[1:3] busy_r)
        else $error("activation did not start a load");
    AST_COPY_RUNS: assert property (
        bulk_w && reg_wdata[1:0] == `SGC_BULK_COPY |-> ##[1:3] busy_r)
        else $error("copy command did not run");
endmodule // sgc_chk
bind sgc_calib sgc_chk u_chk (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r,
    .cmd_ack_r, .external_line_trigger, .pix_valid, .line_valid_r, .data_valid_r, .busy_r);
`default_nettype wire

// ===== tb/sgc_host.sv
// Far side model: line trigger source and sensor pixel stream
`timescale 1ns/1ps
`default_nettype none
module sgc_host (
    input wire logic clk,
    output logic trig,
    output logic pv,
    output logic [11:0] pd
);
    initial begin
        trig = 1'b0;
        pv = 1'b0;
        pd = 12'h000;
    end
    // One triggered line of 16 pixels, first pixel a and the rest b
    task automatic send_line(input logic [11:0] a, input logic [11:0] b);
        int i;
        @(posedge clk);
        trig <= 1'b1;
        repeat (2) @(posedge clk);
        trig <= 1'b0;
        repeat (6) @(posedge clk); // Leave room for the trigger synchroniser
        for (i = 0; i < 16; i++) begin
            pv <= 1'b1;
            pd <= (i == 0) ? a : b;
            @(posedge clk);
        end
        pv <= 1'b0;
        pd <= ~pd; // Idle bus shows no stale pixel
        repeat (3) @(posedge clk);
    endtask
endmodule // sgc_host
`default_nettype wire

// ===== tb/test_sgc_calib.sv
// Self-checking bench for the shading gain calibration block
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defines.vh"
module test_sgc_calib;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic por_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire logic [31:0] reg_rdata_r;
    wire logic cmd_ack_r, trig, pv, line_valid_r, data_valid_r, busy_r;
    wire logic [11:0] pd, pix_out_r;
    int n_mismatch = 0;
    int compares = 0;
    int k = 0;
    int i;
    logic [11:0] out_q [0:15];
    logic [31:0] d;
    logic a;
    sgc_calib dut (.clk(clk), .rstn(rstn), .por_n(por_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .cmd_ack_r(cmd_ack_r), .external_line_trigger(trig), .pix_valid(pv), .pix_data(pd),
        .line_valid_r(line_valid_r), .data_valid_r(data_valid_r), .pix_out_r(pix_out_r),
        .busy_r(busy_r));
    sgc_host host (.clk(clk), .trig(trig), .pv(pv), .pd(pd));
    always #5 clk = ~clk;
    // Capture output pixels of one line
    always @(posedge clk) begin
        if (data_valid_r === 1'b1) begin
            if (k < 16) out_q[k] <= pix_out_r;
            k <= k + 1;
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= dt;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic ak);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        dt = reg_rdata_r;
        ak = cmd_ack_r;
    endtask
    task automatic wait_idle();
        int t;
        repeat (3) @(posedge clk);
        #1;
        for (t = 0; t < 3000 && busy_r !== 1'b0; t++) begin
            @(posedge clk);
            #1;
        end
        if (busy_r !== 1'b0) begin
            check("busy_r wait", busy_r, 0);
            summarize();
        end
    endtask
    // Two consecutive words of a file from a start index
    task automatic chk_file(input logic sel, input logic [4:0] ix, input logic [15:0] e0,
        input logic [15:0] e1);
        wr(`SGC_REG_BULK_CTRL, {19'h0, ix, 3'h0, sel, 4'h0});
        rd(`SGC_REG_BULK_DATA, d, a);
        check("file word", d, {16'h0, e0});
        rd(`SGC_REG_BULK_DATA, d, a);
        check("file next word", d, {16'h0, e1});
    endtask
    task automatic corr(input logic [11:0] e0, input logic [11:0] e1);
        k = 0;
        host.send_line(12'h800, 12'h400);
        check("corrected first pixel", out_q[0], e0);
        check("corrected other pixel", out_q[7], e1);
    endtask
    task automatic calib(input logic [1:0] code, input logic [31:0] mode, input logic [11:0] dk);
        for (i = 0; i < 16; i++) wr(`SGC_REG_DARK, (i << `SGC_DARK_IDX_LSB) | dk);
        wr(`SGC_REG_MODE, mode);
        wr(`SGC_REG_CTRL, {30'h0, code});
        k = 0;
        host.send_line(12'h800, 12'h400);
        check("pixels while collecting", out_q[5], 0);
        check("valid count while collecting", k, 16);
        rd(`SGC_REG_STATUS, d, a);
        check("ack while collecting", a, 0);
        check("data while collecting", d, 0);
        wr(`SGC_REG_MODE, 32'h2);
        for (i = 1; i < 129; i++) host.send_line(12'h800, 12'h400);
        wait_idle();
        rd(`SGC_REG_STATUS, d, a);
        check("user file active", d[0], 1);
        check("lines counted", d[7], 1);
        check("sequencer idle", d[6:1], 1);
        rd(`SGC_REG_MODE, d, a);
        check("mode kept while collecting", d, mode);
        $display("test calibration code %0d done", code);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        check("run time", 0, 1);
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        wait_idle();
        rd(`SGC_REG_STATUS, d, a);
        check("factory active at power-up", d[0], 0);
        rd(8'hFC, d, a);
        check("unmapped ack", a, 1);
        chk_file(1'b1, 5'h00, 16'h1000, 16'h1000);
        $display("test reset done");
        calib(`SGC_GEN_GAIN, 32'h0, 12'h200);
        chk_file(1'b0, 5'h00, 16'h1000, 16'h2000);
        calib(`SGC_GEN_GAIN_DARK, 32'h1, 12'h200);
        chk_file(1'b0, 5'h0F, 16'h2000, 16'h1000);
        chk_file(1'b0, 5'h10, 16'h1000, 16'h3000);
        wr(`SGC_REG_MODE, 32'h3);
        corr(12'h600, 12'h600);
        wr(`SGC_REG_BULK_CTRL, {27'h0, 1'b1, 2'h0, `SGC_BULK_ACTIVATE});
        wait_idle();
        rd(`SGC_REG_STATUS, d, a);
        check("factory activated", d[0], 0);
        corr(12'h600, 12'h200);
        wr(`SGC_REG_BULK_CTRL, {30'h0, `SGC_BULK_ACTIVATE});
        wait_idle();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        wait_idle();
        rd(`SGC_REG_STATUS, d, a);
        check("user kept over reset", d[0], 1);
        wr(`SGC_REG_MODE, 32'h3);
        corr(12'h600, 12'h600);
        $display("test activation done");
        wr(`SGC_REG_BULK_CTRL, {30'h0, `SGC_BULK_COPY});
        wait_idle();
        chk_file(1'b0, 5'h10, 16'h1000, 16'h1000);
        wr(`SGC_REG_BULK_CTRL, {27'h0, 1'b1, 4'h0});
        wr(`SGC_REG_BULK_DATA, 32'h1234);
        chk_file(1'b1, 5'h00, 16'h1000, 16'h1000);
        chk_file(1'b0, 5'h00, 16'h1000, 16'h1000);
        $display("test copy and protection done");
        summarize();
    end
endmodule // test_sgc_calib
`default_nettype wire
